// ### shared/sfe_params.svh
// Register offsets, field positions, reset values and codes of the forwarding engine
`ifndef SFE_PARAMS_SVH
`define SFE_PARAMS_SVH
`define SFE_OFF_PORT_CTL 8'h20
`define SFE_OFF_MODE_CTL 8'h21
`define SFE_OFF_TX_CTL 8'h33
`define SFE_OFF_TX_CTL2 8'h34
`define SFE_OFF_STATUS 8'h35
`define SFE_OFF_PAGE_SEL 8'h4c
`define SFE_OFF_CH_MAP 8'h72
`define SFE_RST_PORT_CTL 8'h03
`define SFE_RST_MODE_CTL 8'h00
`define SFE_RST_TX_CTL 8'h00
`define SFE_RST_TX_CTL2 8'h00
`define SFE_RST_PAGE_SEL 8'h01
`define SFE_RST_CH_MAP 8'he4
`define SFE_BIT_TX_EN 0
`define SFE_BIT_CONT_CLK 1
`define SFE_BIT_CAL_EN 0
`define SFE_BIT_RR 0
`define SFE_SYNC_LSB 2
`define SFE_MERGE_LSB 4
`define SFE_MERGE_ILV 2'h2
`define SFE_PAGE_RD_BIT 4
`define SFE_DT_FS 6'h00
`define SFE_DT_FE 6'h01
`define SFE_DT_LONG_MIN 6'h10
`define SFE_DW 32
`endif

// ### shared/sfe_pkg.sv
// Types shared by the forwarding engine files
package sfe_pkg;
`include "sfe_params.svh"
    typedef struct packed {
        logic [5:0] dt;
        logic [1:0] vc;
        logic [15:0] wc;
    } sfe_hdr_t;
    typedef struct packed {
        logic sop;
        logic eop;
        logic [`SFE_DW-1:0] data;
    } sfe_word_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_HDR = 2'h1,
        ST_DATA = 2'h3
    } sfe_state_t;
    typedef enum logic {
        PH_FS = 1'h0,
        PH_LINE = 1'h1
    } sfe_phase_t;
    typedef enum logic [1:0] {
        LN_HIZ = 2'h0,
        LN_LP11 = 2'h1,
        LN_HS = 2'h3
    } sfe_lane_t;
endpackage

// ### core/sfe_word_xfer.sv
// Toggle handshake carrying one word from the engine clock to the link clock
`timescale 1ns/10ps
module sfe_word_xfer import sfe_pkg::*; #(
    parameter int W = 34
) (
    input wire logic src_clk_i,          // Engine clock
    input wire logic src_rst_i,          // Engine sync reset
    input wire logic src_valid_i,        // Word offered
    input wire logic [W-1:0] src_data_i, // Word
    output logic src_ready_o,            // Crossing idle
    input wire logic dst_clk_i,          // Link clock
    input wire logic dst_rst_i,          // Link sync reset
    output logic dst_valid_o,            // One-cycle word strobe
    output logic [W-1:0] dst_data_o      // Registered word
);
    logic req_r, req_nxt, ack_s1_r, ack_s2_r;
    logic [W-1:0] data_r, data_nxt, dd_r, dd_nxt;
    logic req_s1_r, req_s2_r, req_s3_r, dv_r, dv_nxt;

    // Source side: data held still until the far side echoes the toggle
    assign src_ready_o = (req_r == ack_s2_r);
    always_comb begin
        req_nxt = req_r ^ (src_valid_i & src_ready_o);
        data_nxt = (src_valid_i & src_ready_o) ? src_data_i : data_r;
    end
    always_ff @(posedge src_clk_i) begin
        if (src_rst_i) begin
            req_r <= 1'b0;
            data_r <= '0;
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
        end else begin
            req_r <= req_nxt;
            data_r <= data_nxt;
            ack_s1_r <= req_s3_r;
            ack_s2_r <= ack_s1_r;
        end
    end

    // Destination side: capture once per toggle edge
    always_comb begin
        dv_nxt = req_s2_r ^ req_s3_r;
        dd_nxt = dv_nxt ? data_r : dd_r;
    end
    always_ff @(posedge dst_clk_i) begin
        if (dst_rst_i) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            req_s3_r <= 1'b0;
            dv_r <= 1'b0;
            dd_r <= '0;
        end else begin
            req_s1_r <= req_r;
            req_s2_r <= req_s1_r;
            req_s3_r <= req_s2_r;
            dv_r <= dv_nxt;
            dd_r <= dd_nxt;
        end
    end
    assign dst_valid_o = dv_r;
    assign dst_data_o = dd_r;

    a_xfer_hold: assert property (@(posedge src_clk_i) disable iff (src_rst_i)
        !src_ready_o |=> $stable(data_r))
        else $error("crossing word changed while in flight");
endmodule

// ### core/sfe_fwd_engine.sv
// Stream forwarding engine: two packet buffers to one transmit link
// Summary of operation
// - Setting transmit enable puts idle output lanes into the LP-11 stop state.
// - Round-robin mode imposes no ordering; streams told apart by VC and type.
// - Round-robin forwards packets when ready, alternating ports when both wait.
// - Round-robin passes each channel's frame packets, no cross-port timing needed.
// - Round-robin forwarding runs while its enable bit in mode control is set.
// - Synchronized mode sends frame packets and lines port 0 first, port 1 next.
// - On sync failure stop, discard packets, retry at next frame start.
// - Status shows synchronized; sticky sync-lost flag clears when read.
// - Basic sync keeps whole frames per port; lines alternate; both ends last.
// - Every forwarded packet carries the channel mapped for its receive port.
// - Line-interleave sends one frame start and end, dropping port 1 ones.
// - Line-interleave streams share one channel; engine does not check it.
// - Mode control value 0x04 selects basic synchronized forwarding.
// - Mode control value 0x28 selects synchronized line-interleave forwarding.
// - Writing zero to port control enables both receive ports.
// - A packet is pulled only once it is wholly stored in its buffer.
// - Synchronized status bit reads zero while synchronized forwarding is off.
`timescale 1ns/10ps
`include "sfe_params.svh"
module sfe_fwd_engine import sfe_pkg::*; (
    input wire logic ref_clk_i,                  // Engine clock, 40 MHz
    input wire logic srst_i,                     // Sync reset, active high
    input wire logic tx_clk_i,                   // Link byte clock
    input wire logic [7:0] reg_addr_i,           // Register address
    input wire logic [7:0] reg_wdata_i,          // Register write data
    input wire logic reg_wr_i,                   // Write strobe
    input wire logic reg_rd_i,                   // Read strobe
    output logic [7:0] reg_rdata_o,              // Read data, next cycle
    input wire logic [1:0] buf_rdy_i,            // Whole packet stored, per port
    input wire sfe_hdr_t [1:0] buf_hdr_i,        // Head packet header
    input wire logic [1:0][`SFE_DW-1:0] buf_data_i, // Current payload word
    output logic [1:0] buf_pop_o,                // Pull header or word
    output logic cont_clk_o,                     // Continuous clock request
    output logic cal_en_o,                       // Periodic calibration enable
    output logic tx_valid_o,                     // Link word strobe
    output sfe_word_t tx_word_o,                 // Link word
    output sfe_lane_t lane_state_o               // Lane state
);
    logic [7:0] port_ctl_r, port_ctl_nxt, mode_ctl_r, mode_ctl_nxt, tx_ctl_r, tx_ctl_nxt;
    logic [7:0] tx_ctl2_r, tx_ctl2_nxt, page_r, page_nxt, rdata_r, rdata_nxt, status_w;
    logic [1:0][7:0] map_r, map_nxt;
    logic lost_r, lost_nxt, sync_ok_r, sync_ok_nxt, st_rd;
    sfe_state_t st_r, st_nxt;
    sfe_phase_t phase_r, phase_nxt;
    logic cur_r, cur_nxt, rr_ptr_r, rr_ptr_nxt, exp_r, exp_nxt, drop_r, drop_nxt;
    logic first_fe_r, first_fe_nxt, end_pkt, loss_ev;
    logic [15:0] cnt_r, cnt_nxt, first_wc_r, first_wc_nxt;
    logic [1:0] en, rdy, is_fs, is_fe, is_ln;
    logic fp, lp, tx_en, rr_mode, sync_mode, ilv_mode, long_c, busy;
    logic xf_valid, xf_ready;
    sfe_hdr_t hd, he;
    sfe_word_t xf_word, dw;
    logic dv;
    logic tx_rst_s1_r, tx_rst_r, en_s1_r, en_s2_r, hs_r, hs_nxt;

    // Per-port decode of enables and head packet kind
    for (genvar p = 0; p < 2; p++) begin : g_port
        assign en[p] = ~port_ctl_r[p];
        assign rdy[p] = buf_rdy_i[p] & en[p];
        assign is_fs[p] = (buf_hdr_i[p].dt == `SFE_DT_FS);
        assign is_fe[p] = (buf_hdr_i[p].dt == `SFE_DT_FE);
        assign is_ln[p] = (buf_hdr_i[p].dt >= `SFE_DT_LONG_MIN);
        assign buf_pop_o[p] = busy && (cur_r == p) && (drop_r || xf_ready);
    end

    // Mode decode from the control registers
    assign tx_en = tx_ctl_r[`SFE_BIT_TX_EN];
    assign rr_mode = mode_ctl_r[`SFE_BIT_RR];
    assign sync_mode = !rr_mode && (mode_ctl_r[`SFE_SYNC_LSB+:2] != 2'h0);
    assign ilv_mode = sync_mode
        && (mode_ctl_r[`SFE_MERGE_LSB+:2] == `SFE_MERGE_ILV);
    assign fp = en[0] ? 1'b0 : 1'b1;
    assign lp = en[1] ? 1'b1 : 1'b0;
    assign busy = (st_r != ST_IDLE);
    assign he = buf_hdr_i[exp_r];
    assign st_rd = reg_rd_i && (reg_addr_i == `SFE_OFF_STATUS);
    assign status_w = {5'h00, lost_r, sync_ok_r & sync_mode, busy & ~drop_r};
    assign cont_clk_o = tx_ctl_r[`SFE_BIT_CONT_CLK];
    assign cal_en_o = tx_ctl2_r[`SFE_BIT_CAL_EN];
    assign reg_rdata_o = rdata_r;

    // Register writes and reads; map is paged by the port select
    always_comb begin
        port_ctl_nxt = port_ctl_r;
        mode_ctl_nxt = mode_ctl_r;
        tx_ctl_nxt = tx_ctl_r;
        tx_ctl2_nxt = tx_ctl2_r;
        page_nxt = page_r;
        map_nxt = map_r;
        rdata_nxt = rdata_r;
        if (reg_wr_i) begin
            case (reg_addr_i)
                `SFE_OFF_PORT_CTL: port_ctl_nxt = reg_wdata_i;
                `SFE_OFF_MODE_CTL: mode_ctl_nxt = reg_wdata_i;
                `SFE_OFF_TX_CTL: tx_ctl_nxt = reg_wdata_i;
                `SFE_OFF_TX_CTL2: tx_ctl2_nxt = reg_wdata_i;
                `SFE_OFF_PAGE_SEL: page_nxt = reg_wdata_i;
                `SFE_OFF_CH_MAP: begin
                    if (page_r[0]) map_nxt[0] = reg_wdata_i;
                    if (page_r[1]) map_nxt[1] = reg_wdata_i;
                end
                default: ;
            endcase
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                `SFE_OFF_PORT_CTL: rdata_nxt = port_ctl_r;
                `SFE_OFF_MODE_CTL: rdata_nxt = mode_ctl_r;
                `SFE_OFF_TX_CTL: rdata_nxt = tx_ctl_r;
                `SFE_OFF_TX_CTL2: rdata_nxt = tx_ctl2_r;
                `SFE_OFF_STATUS: rdata_nxt = status_w;
                `SFE_OFF_PAGE_SEL: rdata_nxt = page_r;
                `SFE_OFF_CH_MAP: rdata_nxt = map_r[page_r[`SFE_PAGE_RD_BIT]];
                default: rdata_nxt = 8'h00;
            endcase
        end
        // Sticky flag: a new loss in the reading cycle survives the clear
        lost_nxt = loss_ev | (lost_r & ~st_rd);
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            port_ctl_r <= `SFE_RST_PORT_CTL;
            mode_ctl_r <= `SFE_RST_MODE_CTL;
            tx_ctl_r <= `SFE_RST_TX_CTL;
            tx_ctl2_r <= `SFE_RST_TX_CTL2;
            page_r <= `SFE_RST_PAGE_SEL;
            map_r <= {`SFE_RST_CH_MAP, `SFE_RST_CH_MAP};
            rdata_r <= 8'h00;
            lost_r <= 1'b0;
        end else begin
            port_ctl_r <= port_ctl_nxt;
            mode_ctl_r <= mode_ctl_nxt;
            tx_ctl_r <= tx_ctl_nxt;
            tx_ctl2_r <= tx_ctl2_nxt;
            page_r <= page_nxt;
            map_r <= map_nxt;
            rdata_r <= rdata_nxt;
            lost_r <= lost_nxt;
        end
    end

    // Outgoing word: header with remapped channel, then payload
    always_comb begin
        hd = buf_hdr_i[cur_r];
        hd.vc = map_r[cur_r][{buf_hdr_i[cur_r].vc, 1'b0} +: 2];
        long_c = (buf_hdr_i[cur_r].dt >= `SFE_DT_LONG_MIN) && (buf_hdr_i[cur_r].wc != 16'h0000);
        xf_word.sop = (st_r == ST_HDR);
        xf_word.eop = (st_r == ST_HDR) ? !long_c : (cnt_r == 16'h0001);
        xf_word.data = (st_r == ST_HDR) ? {8'h00, hd} : buf_data_i[cur_r];
        xf_valid = busy && !drop_r;
    end

    // Packet scheduler; mode is sampled only in idle, so packets stay whole
    always_comb begin
        st_nxt = st_r;
        phase_nxt = phase_r;
        cur_nxt = cur_r;
        rr_ptr_nxt = rr_ptr_r;
        exp_nxt = exp_r;
        drop_nxt = drop_r;
        first_fe_nxt = first_fe_r;
        first_wc_nxt = first_wc_r;
        cnt_nxt = cnt_r;
        sync_ok_nxt = sync_ok_r & sync_mode;
        loss_ev = 1'b0;
        end_pkt = 1'b0;
        case (st_r)
            ST_IDLE: begin
                if (!tx_en) begin
                    st_nxt = ST_IDLE;
                end else if (rr_mode) begin
                    if (rdy[rr_ptr_r]) begin
                        cur_nxt = rr_ptr_r;
                        drop_nxt = 1'b0;
                        st_nxt = ST_HDR;
                    end else if (rdy[~rr_ptr_r]) begin
                        cur_nxt = ~rr_ptr_r;
                        drop_nxt = 1'b0;
                        st_nxt = ST_HDR;
                    end
                end else if (sync_mode && !sync_ok_r) begin
                    // Hunting: flush until every enabled port heads a frame start
                    if (((rdy & is_fs) | ~en) == 2'h3 && en != 2'h0) begin
                        sync_ok_nxt = 1'b1;
                        phase_nxt = PH_FS;
                        exp_nxt = fp;
                    end else if (rdy[0] && !is_fs[0]) begin
                        cur_nxt = 1'b0;
                        drop_nxt = 1'b1;
                        st_nxt = ST_HDR;
                    end else if (rdy[1] && !is_fs[1]) begin
                        cur_nxt = 1'b1;
                        drop_nxt = 1'b1;
                        st_nxt = ST_HDR;
                    end
                end else if (sync_mode && rdy[exp_r]) begin
                    cur_nxt = exp_r;
                    st_nxt = ST_HDR;
                    // Only the first port's frame packets survive interleave
                    drop_nxt = ilv_mode && exp_r == lp && fp != lp
                        && (is_fs[exp_r] || is_fe[exp_r]);
                    if (phase_r == PH_FS) begin
                        if (!is_fs[exp_r]) begin
                            loss_ev = 1'b1;
                        end else if (exp_r == lp) begin
                            phase_nxt = PH_LINE;
                            exp_nxt = fp;
                        end else begin
                            exp_nxt = lp;
                        end
                    end else if (is_fs[exp_r]) begin
                        loss_ev = 1'b1;
                    end else if (is_ln[exp_r] || is_fe[exp_r]) begin
                        if (exp_r == fp) begin
                            first_fe_nxt = is_fe[exp_r];
                            first_wc_nxt = he.wc;
                        end else if (is_fe[exp_r] != first_fe_r
                            || (is_ln[exp_r] && he.wc != first_wc_r)) begin
                            loss_ev = 1'b1;
                        end
                        if (!loss_ev) begin
                            exp_nxt = (exp_r == lp) ? fp : lp;
                            if (exp_r == lp && is_fe[exp_r]) phase_nxt = PH_FS;
                        end
                    end
                    if (loss_ev) begin
                        sync_ok_nxt = 1'b0;
                        drop_nxt = 1'b1;
                    end
                end
            end
            ST_HDR: begin
                if (drop_r || xf_ready) begin
                    cnt_nxt = buf_hdr_i[cur_r].wc;
                    st_nxt = long_c ? ST_DATA : ST_IDLE;
                    end_pkt = !long_c;
                end
            end
            ST_DATA: begin
                if (drop_r || xf_ready) begin
                    cnt_nxt = cnt_r - 16'h0001;
                    if (cnt_r == 16'h0001) begin
                        st_nxt = ST_IDLE;
                        end_pkt = 1'b1;
                    end
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
        if (end_pkt) rr_ptr_nxt = ~cur_r;
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            st_r <= ST_IDLE;
            phase_r <= PH_FS;
            cur_r <= 1'b0;
            rr_ptr_r <= 1'b0;
            exp_r <= 1'b0;
            drop_r <= 1'b0;
            first_fe_r <= 1'b0;
            first_wc_r <= 16'h0000;
            cnt_r <= 16'h0000;
            sync_ok_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            phase_r <= phase_nxt;
            cur_r <= cur_nxt;
            rr_ptr_r <= rr_ptr_nxt;
            exp_r <= exp_nxt;
            drop_r <= drop_nxt;
            first_fe_r <= first_fe_nxt;
            first_wc_r <= first_wc_nxt;
            cnt_r <= cnt_nxt;
            sync_ok_r <= sync_ok_nxt;
        end
    end

    // Word crossing into the link clock; engine stalls until each word lands
    sfe_word_xfer #(.W($bits(sfe_word_t))) u_xfer (
        .src_clk_i(ref_clk_i),
        .src_rst_i(srst_i),
        .src_valid_i(xf_valid),
        .src_data_i(xf_word),
        .src_ready_o(xf_ready),
        .dst_clk_i(tx_clk_i),
        .dst_rst_i(tx_rst_r),
        .dst_valid_o(dv),
        .dst_data_o(dw)
    );

    // Link domain: reset and enable brought over by two flip-flops each
    sfe_lane_t lane_r, lane_nxt;
    always_comb begin
        hs_nxt = dv ? !dw.eop : hs_r;
        lane_nxt = !en_s2_r ? LN_HIZ : ((dv || hs_r) ? LN_HS : LN_LP11);
    end
    always_ff @(posedge tx_clk_i) begin
        tx_rst_s1_r <= srst_i;
        tx_rst_r <= tx_rst_s1_r;
    end
    always_ff @(posedge tx_clk_i) begin
        if (tx_rst_r) begin
            en_s1_r <= 1'b0;
            en_s2_r <= 1'b0;
            hs_r <= 1'b0;
            lane_r <= LN_HIZ;
        end else begin
            en_s1_r <= tx_en;
            en_s2_r <= en_s1_r;
            hs_r <= hs_nxt;
            lane_r <= lane_nxt;
        end
    end
    assign tx_valid_o = dv;
    assign tx_word_o = dw;
    assign lane_state_o = lane_r;

    a_lane_stop_state: assert property (@(posedge tx_clk_i) disable iff (tx_rst_r)
        (en_s2_r && !dv && !hs_r) |=> (lane_r == LN_LP11))
        else $error("enabled idle lanes not in stop state");
    a_pull_whole_pkt: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (!busy && st_nxt == ST_HDR) |-> buf_rdy_i[cur_nxt] && en[cur_nxt])
        else $error("packet pulled before fully stored");
    a_rr_ptr_rotate: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        end_pkt |=> (rr_ptr_r == !$past(cur_r)))
        else $error("round-robin pointer did not move on");
    a_rr_fair_pick: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (!busy && tx_en && rr_mode && rdy == 2'h3) |=> (st_r == ST_HDR && cur_r == $past(rr_ptr_r)))
        else $error("round-robin ignored priority port");
    a_sync_bit_off: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (st_rd && !sync_mode) |=> !reg_rdata_o[1])
        else $error("sync status set while sync forwarding off");
    a_lost_sticky_set: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        loss_ev |=> (lost_r && !sync_ok_r && drop_r) ##1 (!xf_valid || !busy))
        else $error("sync loss not flagged or packet sent");
    a_lost_read_clear: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (st_rd && lost_r && !loss_ev) |=> (reg_rdata_o[2] && !lost_r))
        else $error("sync-lost flag not reported and cleared");
    a_ilv_frame_drop: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (!busy && tx_en && ilv_mode && sync_ok_r && exp_r && en[0] && rdy[1] && is_fe[1])
        |=> drop_r)
        else $error("second port frame packet not dropped");
    a_vc_remap: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (xf_valid && xf_ready && st_r == ST_HDR)
        |-> (xf_word.data[17:16] == map_r[cur_r][{buf_hdr_i[cur_r].vc, 1'b0} +: 2]))
        else $error("packet channel not remapped");
    a_off_no_pull: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (!busy && !rr_mode && !sync_mode) |=> !busy)
        else $error("forwarding started with no mode selected");
endmodule

// ### verification/sfe_rx_model.sv
// Behavioural link receiver that logs the type and channel byte of every packet header it sees
`timescale 1ns/10ps
module sfe_rx_model import sfe_pkg::*; (
    input wire logic tx_clk_i,      // Link clock
    input wire logic tx_valid_i,    // Word strobe
    input wire sfe_word_t tx_word_i, // Link word
    input wire sfe_lane_t lane_i     // Lane state
);
    logic [7:0] hq[$];
    logic [31:0] last_eop = '0;
    logic seen = 1'b0;
    int words = 0, eops = 0, lane_err = 0;
    // Streams are told apart only by channel, type and arrival order
    // Lanes must be in high speed the cycle after every strobe
    always @(posedge tx_clk_i) begin
        if (seen && lane_i !== LN_HS) lane_err++;
        seen = (tx_valid_i === 1'b1);
        if (tx_valid_i === 1'b1) begin
            words++;
            if (tx_word_i.sop === 1'b1) hq.push_back(tx_word_i.data[23:16]);
            if (tx_word_i.eop === 1'b1) begin
                eops++;
                last_eop = tx_word_i.data;
            end
        end
    end
endmodule

// ### verification/sfe_tb.sv
// Self-checking bench for the stream forwarding engine
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module testbench import sfe_pkg::*;;
    logic ref_clk_i = 0, srst_i = 1, tx_clk_i = 0, reg_wr_i = 0, reg_rd_i = 0;
    logic [7:0] reg_addr_i = '0, reg_wdata_i = '0, reg_rdata_o;
    logic [1:0] buf_rdy_i = '0, buf_pop_o, pend = '0;
    sfe_hdr_t [1:0] buf_hdr_i = '0;
    logic [1:0][31:0] buf_data_i = '0;
    logic [15:0] cnt [2] = '{16'h0, 16'h0};
    logic cont_clk_o, cal_en_o, tx_valid_o;
    sfe_word_t tx_word_o;
    sfe_lane_t lane_state_o;
    int err_total = 0, total_checks = 0, cyc = 0;
    logic [7:0] ra [8] = '{8'h20, 8'h21, 8'h33, 8'h34, 8'h4c, 8'h72, 8'h35, 8'h10};
    logic [7:0] rv [8] = '{8'h03, 8'h00, 8'h00, 8'h00, 8'h01, 8'he4, 8'h00, 8'h00};
    sfe_fwd_engine dut (.ref_clk_i, .srst_i, .tx_clk_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .buf_rdy_i, .buf_hdr_i, .buf_data_i, .buf_pop_o, .cont_clk_o,
        .cal_en_o, .tx_valid_o, .tx_word_o, .lane_state_o);
    sfe_rx_model rx (.tx_clk_i, .tx_valid_i(tx_valid_o), .tx_word_i(tx_word_o),
        .lane_i(lane_state_o));
    // Two unrelated clocks
    always #12.5 ref_clk_i = ~ref_clk_i;
    always #32 tx_clk_i = ~tx_clk_i;
    // Pop capture and hang guard; about fifty times the expected run
    always @(posedge ref_clk_i) begin
        pend <= buf_pop_o;
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            give_verdict();
        end
    end
    // Source buffers step at the falling edge so nothing races the pop
    always @(negedge ref_clk_i) for (int p = 0; p < 2; p++) if (pend[p]) begin
        cnt[p] = cnt[p] + 16'h1;
        buf_data_i[p] = {16'h0, cnt[p]};
        if (cnt[p] > buf_hdr_i[p].wc) buf_rdy_i[p] = 1'b0;
    end
    task automatic acc(input logic [7:0] a, d, input logic w);
        @(negedge ref_clk_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = w;
        reg_rd_i = !w;
        @(negedge ref_clk_i);
        reg_wr_i = 0;
        reg_rd_i = 0;
    endtask
    // Offer one whole packet on each port, wait until both are drained
    task automatic pk(input logic [5:0] d0, d1, input logic [15:0] wc);
        int n;
        n = 0;
        @(negedge ref_clk_i);
        for (int p = 0; p < 2; p++) begin
            buf_hdr_i[p] = '{p ? d1 : d0, 2'h0, wc}; // Both sensors on channel 0
            cnt[p] = 16'h0;
        end
        buf_rdy_i = 2'h3;
        while (buf_rdy_i !== 2'h0 && n < 3000) begin
            @(negedge ref_clk_i);
            n++;
        end
        `CHK(buf_rdy_i, 2'h0)
        repeat (40) @(negedge ref_clk_i);
    endtask
    // Logged header bytes against n expected bytes, first one leftmost
    task automatic hdrs(input int n, input logic [47:0] e);
        `CHK(rx.hq.size(), n)
        for (int i = 0; i < n; i++) `CHK(rx.hq[i], e[8*(n-1-i) +: 8])
        rx.hq.delete();
    endtask
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Reset values, port 1 channel remap, transmitter start-up
    task automatic t_setup();
        foreach (ra[i]) begin
            acc(ra[i], 8'h00, 0);
            `CHK(reg_rdata_o, rv[i])
        end
        `CHK(lane_state_o, LN_HIZ)
        acc(8'h4c, 8'h12, 1);
        acc(8'h72, 8'he5, 1);
        acc(8'h72, 8'h00, 0);
        `CHK(reg_rdata_o, 8'he5)
        acc(8'h33, 8'h03, 1);
        acc(8'h34, 8'h01, 1);
        repeat (20) @(negedge ref_clk_i);
        `CHK(lane_state_o, LN_LP11)
        `CHK({cont_clk_o, cal_en_o}, 2'h3)
    endtask
    // Best-effort round robin: one line packet per port
    task automatic t_round_robin();
        acc(8'h21, 8'h01, 1);
        acc(8'h20, 8'h00, 1);
        pk(6'h2a, 6'h2a, 16'h2);
        `CHK(rx.words, 6)
        `CHK(rx.eops, 2)
        `CHK(rx.last_eop, 32'h2)
        `CHK(rx.hq[0][1:0] ^ rx.hq[1][1:0], 2'h1)
        hdrs(2, 48'ha8a9);
    endtask
    // Basic synchronized frame: lock, one line pair, frame end
    task automatic t_sync_basic();
        acc(8'h21, 8'h00, 1);
        acc(8'h21, 8'h04, 1);
        pk(6'h00, 6'h00, 16'h0);
        pk(6'h2a, 6'h2a, 16'h2);
        acc(8'h35, 8'h00, 0);
        `CHK(reg_rdata_o[1], 1'b1)
        pk(6'h01, 6'h01, 16'h0);
        hdrs(6, 48'h0001a8a90405);
    endtask
    // Lines where a frame start is due break the lock
    task automatic t_sync_loss();
        pk(6'h2a, 6'h2a, 16'h2);
        acc(8'h35, 8'h00, 0);
        `CHK(reg_rdata_o[2:1], 2'h2)
        acc(8'h35, 8'h00, 0);
        `CHK(reg_rdata_o[2], 1'b0)
        hdrs(0, 48'h0);
    endtask
    // Line interleave: only the first port's frame packets survive
    task automatic t_interleave();
        acc(8'h21, 8'h00, 1);
        acc(8'h21, 8'h28, 1);
        pk(6'h00, 6'h00, 16'h0);
        pk(6'h2a, 6'h2a, 16'h2);
        pk(6'h01, 6'h01, 16'h0);
        hdrs(4, 48'h00a8a904);
    endtask
    // Shutdown in the required order releases the lanes
    task automatic t_shutdown();
        acc(8'h20, 8'h03, 1);
        acc(8'h34, 8'h00, 1);
        acc(8'h33, 8'h01, 1);
        acc(8'h33, 8'h00, 1);
        repeat (20) @(negedge ref_clk_i);
        `CHK(lane_state_o, LN_HIZ)
        `CHK({cont_clk_o, cal_en_o}, 2'h0)
        `CHK(rx.lane_err, 0)
    endtask
    // Main sequence
    initial begin
        repeat (10) @(negedge ref_clk_i);
        srst_i = 0;
        t_setup();
        t_round_robin();
        t_sync_basic();
        t_sync_loss();
        t_interleave();
        t_shutdown();
        give_verdict();
    end
endmodule
